// ### common/fpr_pkg.sv
// package: constants, field layouts and carrier types of the fuse parity and readback block
package fpr_pkg;

  // ****************************************
  // code widths and fuse counts
  // ****************************************
  localparam int unsigned GAIN2_W = 3;
  localparam int unsigned GAIN1_W = 7;
  localparam int unsigned OFFSET_W = 8;
  localparam int unsigned CODE_BITS = 18;
  localparam int unsigned FUSE_BITS = 21;
  localparam int unsigned READ_W = 8;

  // ****************************************
  // serial packet layout, first sent bit is bit 37
  // ****************************************
  localparam int unsigned PKT_W = 38;
  localparam int unsigned START_HI = 37;
  localparam int unsigned START_LO = 26;
  localparam int unsigned FUNC_HI = 25;
  localparam int unsigned FUNC_LO = 24;
  localparam int unsigned PARAM_HI = 23;
  localparam int unsigned PARAM_LO = 22;
  localparam int unsigned DUMMY_HI = 21;
  localparam int unsigned DUMMY_LO = 20;
  localparam int unsigned VALUE_HI = 19;
  localparam int unsigned VALUE_LO = 12;
  localparam int unsigned END_HI = 11;
  localparam int unsigned END_LO = 0;
  localparam logic [11:0] START_PATTERN = 12'h801;
  localparam logic [11:0] END_PATTERN = 12'h7fe;
  localparam logic [1:0] DUMMY_PATTERN = 2'h2;

  // ****************************************
  // function and parameter field codes
  // ****************************************
  localparam logic [1:0] FUNC_SENSE = 2'h0;
  localparam logic [1:0] FUNC_SIMULATE = 2'h1;
  localparam logic [1:0] FUNC_PROGRAM = 2'h2;
  localparam logic [1:0] FUNC_READ = 2'h3;
  localparam logic [1:0] PARAM_GAIN2 = 2'h0;
  localparam logic [1:0] PARAM_GAIN1 = 2'h1;
  localparam logic [1:0] PARAM_OFFSET = 2'h2;
  localparam logic [1:0] PARAM_OTHER = 2'h3;

  // ****************************************
  // read shifting
  // ****************************************
  localparam logic [2:0] LAST_PULSE = 3'h7;
  localparam logic [2:0] PULSE_RESET = 3'h0;

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam int unsigned WB_AW = 4;
  localparam logic [3:0] STATUS_ADDR = 4'h0;
  localparam logic [3:0] CODES_ADDR = 4'h4;
  localparam logic [3:0] CTRL_ADDR = 4'h8;
  localparam logic [3:0] PKTCNT_ADDR = 4'hc;
  localparam logic CTRL_RESET = 1'b1;
  localparam logic [7:0] PKTCNT_RESET = 8'h00;

  // ****************************************
  // carrier types
  // ****************************************
  typedef struct packed {
    logic [GAIN2_W-1:0] secondGainCodeBits;
    logic [GAIN1_W-1:0] firstGainCodeBits;
    logic [OFFSET_W-1:0] offsetCodeBits;
  } fpr_codes_t;

  typedef struct packed {
    fpr_codes_t codes;
    logic parityFuseBit;
    logic testFuseBit;
    logic lockFuseBit;
  } fpr_fuse_t;

  localparam fpr_codes_t CODES_RESET = '0;

  typedef enum logic {RD_IDLE, RD_SHIFT} fpr_rd_state_t;

endpackage

// ### rtl/fpr_fuse_cells.sv
// module: registered logic levels of all fuse cells
`timescale 1ns/10ps
module fpr_fuse_cells
  import fpr_pkg::*;
(
  mclk,
  rst_b,
  fuseAboveThreshold,
  fuseState
);
  input wire logic mclk;
  input wire logic rst_b;
  input wire logic [fpr_pkg::FUSE_BITS-1:0] fuseAboveThreshold;
  output fpr_pkg::fpr_fuse_t fuseState;

  fpr_fuse_t fuse_reg;
  fpr_fuse_t fuse_next;

  // ****************************************
  // cell judgement
  // ****************************************

  // sense level above threshold means blown and reads 1, below reads 0
  always_comb
  begin
    fuse_next = fuseAboveThreshold;
  end

  // register cell levels, all intact after reset
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      fuse_reg <= '0;
    end
    else
    begin
      fuse_reg <= fuse_next;
    end
  end

  assign fuseState = fuse_reg;

endmodule

// ### rtl/fpr_fuse_parity_readback.sv
// module: top of the fuse parity and readback block with packet decode and register slave
//
// Behaviour
// - lock intact holds parity error at zero
// - lock blown passes parity comparison out
// - parity error forces output to low rail
// - data parity is xor of 18 bits
// - comparison result comes from two-input xor
// - read packet enters read mode for parameter
// - load fuse value, show msb on pin
// - serial falling edge shifts, msb first
// - eighth pulse disconnects pin, ends read
// - short parameters padded with upper zeros
// - readback bit joins pin only in read
// - fuse cell reads 0 intact, 1 blown
// - sense packet value bit0 picks low current
// - sense choice volatile, normal after reset
// - function field: sense, simulate, program, read
// - parameter field: gain2, gain1, offset, other
// - decode only with valid start and end
// - fuse values used only after lock blown
//
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
module fpr_fuse_parity_readback
  import fpr_pkg::*;
(
  mclk,
  rst_b,
  serialInputPin,
  packetStrobe,
  packetWord,
  fuseAboveThreshold,
  wb_adr_i,
  wb_dat_i,
  wb_sel_i,
  wb_we_i,
  wb_cyc_i,
  wb_stb_i,
  wb_dat_o,
  wb_ack_o,
  activeCodes,
  parityErrorFlag,
  forceLowRail,
  senseLowCurrent,
  readbackConnect,
  readbackBit,
  readModeActive
);
  input wire logic mclk;
  input wire logic rst_b;
  input wire logic serialInputPin;
  input wire logic packetStrobe;
  input wire logic [fpr_pkg::PKT_W-1:0] packetWord;
  input wire logic [fpr_pkg::FUSE_BITS-1:0] fuseAboveThreshold;
  input wire logic [fpr_pkg::WB_AW-1:0] wb_adr_i;
  input wire logic [31:0] wb_dat_i;
  input wire logic [3:0] wb_sel_i;
  input wire logic wb_we_i;
  input wire logic wb_cyc_i;
  input wire logic wb_stb_i;
  output logic [31:0] wb_dat_o;
  output logic wb_ack_o;
  output fpr_pkg::fpr_codes_t activeCodes;
  output logic parityErrorFlag;
  output logic forceLowRail;
  output logic senseLowCurrent;
  output logic readbackConnect;
  output logic readbackBit;
  output logic readModeActive;

  fpr_fuse_t fuseState;
  logic dataParity;
  logic parityError;

  // ****************************************
  // submodules
  // ****************************************

  // fuse cell levels
  fpr_fuse_cells uFuseCells (
    .mclk(mclk),
    .rst_b(rst_b),
    .fuseAboveThreshold(fuseAboveThreshold),
    .fuseState(fuseState)
  );

  // parity check chain
  fpr_parity_check uParity (
    .mclk(mclk),
    .rst_b(rst_b),
    .fuseState(fuseState),
    .dataParity(dataParity),
    .parityError(parityError)
  );

  // ****************************************
  // packet decode
  // ****************************************

  // value of one parameter from the fuses, upper bits padded with zeros
  function automatic logic [READ_W-1:0] fuseParam(input fpr_fuse_t f, input logic [1:0] sel);
    logic [READ_W-1:0] v;
    v = '0;
    if (sel == PARAM_GAIN2)
    begin
      v = {{(READ_W-GAIN2_W){1'b0}}, f.codes.secondGainCodeBits};
    end
    else if (sel == PARAM_GAIN1)
    begin
      v = {{(READ_W-GAIN1_W){1'b0}}, f.codes.firstGainCodeBits};
    end
    else if (sel == PARAM_OFFSET)
    begin
      v = f.codes.offsetCodeBits;
    end
    else
    begin
      v = {5'h00, f.parityFuseBit, f.testFuseBit, f.lockFuseBit};
    end
    return v;
  endfunction

  logic [11:0] pktStart;
  logic [11:0] pktEnd;
  logic [1:0] pktDummy;
  logic [1:0] pktFunc;
  logic [1:0] pktParam;
  logic [7:0] pktValue;
  logic pktAccepted;
  logic packetEnable_reg;

  // split fields and check framing, packets ignored while read shifting
  always_comb
  begin
    pktStart = packetWord[START_HI:START_LO];
    pktEnd = packetWord[END_HI:END_LO];
    pktDummy = packetWord[DUMMY_HI:DUMMY_LO];
    pktFunc = packetWord[FUNC_HI:FUNC_LO];
    pktParam = packetWord[PARAM_HI:PARAM_LO];
    pktValue = packetWord[VALUE_HI:VALUE_LO];
    pktAccepted = packetStrobe && packetEnable_reg && (pktStart == START_PATTERN)
      && (pktEnd == END_PATTERN) && (pktDummy == DUMMY_PATTERN)
      && !readModeActive;
  end

  // ****************************************
  // volatile codes, sense current, active codes
  // ****************************************
  fpr_codes_t simCodes_reg;
  fpr_codes_t simCodes_next;
  logic senseLow_reg;
  logic senseLow_next;
  fpr_codes_t active_reg;
  fpr_codes_t active_next;
  logic parErr_reg;
  logic parErr_next;
  logic lowRail_reg;
  logic lowRail_next;

  // simulate writes volatile codes until locked, sense packet picks current
  always_comb
  begin
    simCodes_next = simCodes_reg;
    senseLow_next = senseLow_reg;
    if (pktAccepted && (pktFunc == FUNC_SIMULATE) && !fuseState.lockFuseBit)
    begin
      if (pktParam == PARAM_GAIN2)
      begin
        simCodes_next.secondGainCodeBits = pktValue[GAIN2_W-1:0];
      end
      else if (pktParam == PARAM_GAIN1)
      begin
        simCodes_next.firstGainCodeBits = pktValue[GAIN1_W-1:0];
      end
      else if (pktParam == PARAM_OFFSET)
      begin
        simCodes_next.offsetCodeBits = pktValue;
      end
    end
    if (pktAccepted && (pktFunc == FUNC_SENSE) && (pktParam == PARAM_GAIN2))
    begin
      senseLow_next = pktValue[0];
    end
    active_next = fuseState.lockFuseBit ? fuseState.codes : simCodes_reg;
    parErr_next = parityError;
    lowRail_next = parityError;
  end

  // register volatile state, normal sense current after reset
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      simCodes_reg <= CODES_RESET;
      senseLow_reg <= 1'b0;
      active_reg <= CODES_RESET;
      parErr_reg <= 1'b0;
      lowRail_reg <= 1'b0;
    end
    else
    begin
      simCodes_reg <= simCodes_next;
      senseLow_reg <= senseLow_next;
      active_reg <= active_next;
      parErr_reg <= parErr_next;
      lowRail_reg <= lowRail_next;
    end
  end

  // ****************************************
  // read mode shifter
  // ****************************************
  fpr_rd_state_t rdState_reg;
  fpr_rd_state_t rdState_next;
  logic [READ_W-1:0] shift_reg;
  logic [READ_W-1:0] shift_next;
  logic [2:0] pulses_reg;
  logic [2:0] pulses_next;
  logic pinPrev_reg;
  logic pinFall;

  // load on read packet, shift on each falling edge, stop on the eighth
  always_comb
  begin
    rdState_next = rdState_reg;
    shift_next = shift_reg;
    pulses_next = pulses_reg;
    pinFall = pinPrev_reg && !serialInputPin;
    case (rdState_reg)
      RD_IDLE:
      begin
        if (pktAccepted && (pktFunc == FUNC_READ))
        begin
          rdState_next = RD_SHIFT;
          shift_next = fuseParam(fuseState, pktParam);
          pulses_next = PULSE_RESET;
        end
      end
      RD_SHIFT:
      begin
        if (pinFall)
        begin
          if (pulses_reg == LAST_PULSE)
          begin
            rdState_next = RD_IDLE;
            shift_next = '0;
          end
          else
          begin
            shift_next = {shift_reg[READ_W-2:0], 1'b0};
            pulses_next = pulses_reg + 3'h1;
          end
        end
      end
      default:
      begin
        rdState_next = RD_IDLE;
      end
    endcase
  end

  // register shifter
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      rdState_reg <= RD_IDLE;
      shift_reg <= '0;
      pulses_reg <= PULSE_RESET;
      pinPrev_reg <= 1'b0;
    end
    else
    begin
      rdState_reg <= rdState_next;
      shift_reg <= shift_next;
      pulses_reg <= pulses_next;
      pinPrev_reg <= serialInputPin;
    end
  end

  // ****************************************
  // wishbone slave
  // ****************************************
  logic ack_next;
  logic [31:0] rdData_next;
  logic [31:0] rdData_reg;
  logic ack_reg;
  logic packetEnable_next;
  logic [7:0] pktCount_reg;
  logic [7:0] pktCount_next;
  logic wbHit;

  // one-wait-state answer, unmapped addresses read zero and ignore writes
  always_comb
  begin
    wbHit = wb_cyc_i && wb_stb_i && !ack_reg;
    ack_next = wbHit;
    rdData_next = 32'h00000000;
    packetEnable_next = packetEnable_reg;
    pktCount_next = pktAccepted ? pktCount_reg + 8'h01 : pktCount_reg;
    if (wb_adr_i == STATUS_ADDR)
    begin
      rdData_next = {25'h0000000, dataParity, senseLow_reg, readbackBit, readModeActive,
        fuseState.parityFuseBit, fuseState.lockFuseBit, parErr_reg};
    end
    else if (wb_adr_i == CODES_ADDR)
    begin
      rdData_next = {14'h0000, active_reg};
    end
    else if (wb_adr_i == CTRL_ADDR)
    begin
      rdData_next = {31'h00000000, packetEnable_reg};
      if (wbHit && wb_we_i && wb_sel_i[0])
      begin
        packetEnable_next = wb_dat_i[0];
      end
    end
    else if (wb_adr_i == PKTCNT_ADDR)
    begin
      rdData_next = {24'h000000, pktCount_reg};
    end
  end

  // register bus state
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      ack_reg <= 1'b0;
      rdData_reg <= 32'h00000000;
      packetEnable_reg <= CTRL_RESET;
      pktCount_reg <= PKTCNT_RESET;
    end
    else
    begin
      ack_reg <= ack_next;
      rdData_reg <= rdData_next;
      packetEnable_reg <= packetEnable_next;
      pktCount_reg <= pktCount_next;
    end
  end

  // ****************************************
  // outputs, all straight from flip-flops
  // ****************************************
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdData_reg;
  assign activeCodes = active_reg;
  assign parityErrorFlag = parErr_reg;
  assign forceLowRail = lowRail_reg;
  assign senseLowCurrent = senseLow_reg;
  assign readModeActive = (rdState_reg == RD_SHIFT);
  assign readbackConnect = (rdState_reg == RD_SHIFT);
  assign readbackBit = shift_reg[READ_W-1];

endmodule

// ### rtl/fpr_parity_check.sv
// module: parity over stored codes, compare with parity fuse, gated by lock fuse
`timescale 1ns/10ps
module fpr_parity_check
  import fpr_pkg::*;
(
  mclk,
  rst_b,
  fuseState,
  dataParity,
  parityError
);
  input wire logic mclk;
  input wire logic rst_b;
  input fpr_pkg::fpr_fuse_t fuseState;
  output logic dataParity;
  output logic parityError;

  logic wideXorCell;
  logic compareXorCell;
  logic faultGateCell;
  logic dataParity_reg;
  logic parityError_reg;

  // ****************************************
  // parity gates
  // ****************************************

  // odd count of ones over all 18 code bits gives 1
  always_comb
  begin
    wideXorCell = ^fuseState.codes;
    compareXorCell = wideXorCell ^ fuseState.parityFuseBit;
    faultGateCell = compareXorCell & fuseState.lockFuseBit;
  end

  // register results
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      dataParity_reg <= 1'b0;
      parityError_reg <= 1'b0;
    end
    else
    begin
      dataParity_reg <= wideXorCell;
      parityError_reg <= faultGateCell;
    end
  end

  assign dataParity = dataParity_reg;
  assign parityError = parityError_reg;

endmodule

// ### verification/fpr_fuse_parity_readback_sva.sv
// checker: port-level timing relations of the fuse parity and readback block
`timescale 1ns/10ps
module fpr_fuse_parity_readback_sva
  import fpr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic serialInputPin,
  input wire logic packetStrobe,
  input wire logic [fpr_pkg::PKT_W-1:0] packetWord,
  input wire logic [fpr_pkg::FUSE_BITS-1:0] fuseAboveThreshold,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input fpr_pkg::fpr_codes_t activeCodes,
  input wire logic parityErrorFlag,
  input wire logic forceLowRail,
  input wire logic senseLowCurrent,
  input wire logic readbackConnect,
  input wire logic readbackBit,
  input wire logic readModeActive
);
  // ****
  // helpers
  // ****
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  logic [3:0] fallCnt;
  wire logic framed = packetWord[37:26] == START_PATTERN && packetWord[11:0] == END_PATTERN
    && packetWord[21:20] == DUMMY_PATTERN;
  // counts shift strobes since read entry
  always_ff @(posedge mclk)
  begin
    if (!rst_b || !readModeActive)
      fallCnt <= 4'h0;
    else if ($fell(serialInputPin))
      fallCnt <= fallCnt + 4'h1;
  end
  // ****
  // properties
  // ****
  property p_lockIntact;
    !fuseAboveThreshold[0] [*4] |-> !parityErrorFlag;
  endproperty
  a_lockIntact: assert property (p_lockIntact) else $error("error flag with lock intact");
  property p_parityOut;
    (fuseAboveThreshold[0] && $stable(fuseAboveThreshold)) [*4] |-> parityErrorFlag == ^fuseAboveThreshold[20:2];
  endproperty
  a_parityOut: assert property (p_parityOut) else $error("error flag wrong");
  property p_railFollows;
    forceLowRail == parityErrorFlag;
  endproperty
  a_railFollows: assert property (p_railFollows) else $error("rail force differs");
  property p_fuseCodes;
    (fuseAboveThreshold[0] && $stable(fuseAboveThreshold)) [*4] |-> activeCodes == fuseAboveThreshold[20:3];
  endproperty
  a_fuseCodes: assert property (p_fuseCodes) else $error("codes not from fuses");
  property p_readEntry;
    $rose(readModeActive) |-> $past(packetStrobe) && $past(framed) && $past(packetWord[25:24]) == FUNC_READ;
  endproperty
  a_readEntry: assert property (p_readEntry) else $error("read entry without read word");
  property p_readMsb;
    $rose(readModeActive) |-> readbackBit == ($past(packetWord[23:22]) == PARAM_OFFSET && fuseAboveThreshold[10]);
  endproperty
  a_readMsb: assert property (p_readMsb) else $error("first readback bit wrong");
  property p_readOnly;
    readbackConnect == readModeActive && (readModeActive || !readbackBit);
  endproperty
  a_readOnly: assert property (p_readOnly) else $error("readback outside read");
  property p_readHold;
    readModeActive && $fell(serialInputPin) && fallCnt < 4'h7 |-> ##2 readModeActive;
  endproperty
  a_readHold: assert property (p_readHold) else $error("read ended early");
  property p_readEnd;
    readModeActive && $fell(serialInputPin) && fallCnt == 4'h7 |-> ##2 !readModeActive;
  endproperty
  a_readEnd: assert property (p_readEnd) else $error("read not ended");
  property p_senseSet;
    packetStrobe && framed && !readModeActive && packetWord[25:22] == 4'h0 |=> senseLowCurrent == $past(packetWord[12]);
  endproperty
  a_senseSet: assert property (p_senseSet) else $error("sense choice wrong");
  property p_senseHold;
    !packetStrobe || readModeActive |=> $stable(senseLowCurrent);
  endproperty
  a_senseHold: assert property (p_senseHold) else $error("sense moved");
  property p_wbAck;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wbAck: assert property (p_wbAck) else $error("bus ack timing wrong");
endmodule

bind fpr_fuse_parity_readback fpr_fuse_parity_readback_sva u_sva (.mclk, .rst_b, .serialInputPin, .packetStrobe,
  .packetWord, .fuseAboveThreshold, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .activeCodes, .parityErrorFlag,
  .forceLowRail, .senseLowCurrent, .readbackConnect, .readbackBit, .readModeActive);

// ### verification/fpr_programmer_model.sv
// partner: external programmer sending packet words and read shift pulses
`timescale 1ns/10ps
module fpr_programmer_model
  import fpr_pkg::*;
(
  input wire logic mclk,
  output logic serialInputPin,
  output logic packetStrobe,
  output logic [fpr_pkg::PKT_W-1:0] packetWord
);
  // serial line idles high
  initial
  begin
    serialInputPin = 1'b1;
    packetStrobe = 1'b0;
    packetWord = '0;
  end
  // one whole word; a spoiled start field when good is low
  task automatic sendPkt(input logic [1:0] func, input logic [1:0] param, input logic [7:0] value, input logic good);
  begin
    @(posedge mclk);
    packetWord <= {good ? START_PATTERN : 12'h800, func, param, DUMMY_PATTERN, value, END_PATTERN};
    packetStrobe <= 1'b1;
    @(posedge mclk);
    packetStrobe <= 1'b0;
    packetWord <= ~packetWord; // released word keeps no stale value
  end
  endtask
  // one shift strobe, falling edge first
  task automatic pulseShift();
  begin
    @(posedge mclk);
    serialInputPin <= 1'b0;
    repeat (2) @(posedge mclk);
    serialInputPin <= 1'b1;
    repeat (2) @(posedge mclk);
  end
  endtask
endmodule

// ### verification/test_fpr_fuse_parity_readback.sv
// testbench: parity, readback, sense current and bus checks of the fuse block
`timescale 1ns/10ps
module test_fpr_fuse_parity_readback;
  import fpr_pkg::*;
  logic mclk;
  logic rst_b;
  logic serialInputPin;
  logic packetStrobe;
  logic [PKT_W-1:0] packetWord;
  logic [FUSE_BITS-1:0] fuseAboveThreshold;
  logic [WB_AW-1:0] wb_adr_i;
  logic [31:0] wb_dat_i;
  logic [3:0] wb_sel_i;
  logic wb_we_i;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  fpr_codes_t activeCodes;
  logic parityErrorFlag;
  logic forceLowRail;
  logic senseLowCurrent;
  logic readbackConnect;
  logic readbackBit;
  logic readModeActive;
  logic [31:0] rd;
  logic [21:0] rows [9];
  int num_errors;
  int tests_run;
  fpr_fuse_parity_readback DUT (.mclk, .rst_b, .serialInputPin, .packetStrobe, .packetWord,
    .fuseAboveThreshold, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
    .wb_ack_o, .activeCodes, .parityErrorFlag, .forceLowRail, .senseLowCurrent, .readbackConnect,
    .readbackBit, .readModeActive);
  fpr_programmer_model partner (.mclk, .serialInputPin, .packetStrobe, .packetWord);
  // ****
  // clock, compares, bus and readback tasks
  // ****
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic chkBit(input string what, input logic seen, input logic exp);
  begin
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %b seen %b", what, exp, seen);
    end
  end
  endtask
  task automatic chkWord(input string what, input logic [31:0] seen, input logic [31:0] exp);
  begin
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask
  // classic single cycle, held until ack is sampled
  task automatic wbCycle(input logic [3:0] adr, input logic we, input logic [31:0] dat);
    int n;
  begin
    n = 0;
    @(posedge mclk);
    wb_adr_i <= adr;
    wb_we_i <= we;
    wb_dat_i <= dat;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    @(posedge mclk);
    while (wb_ack_o !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge mclk);
    end
    chkBit("wb_ack_o", wb_ack_o, 1'b1); // a missing answer counts as a mismatch
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  end
  endtask
  // enter read mode, walk all eight bits, a stray sense word in mid-read
  task automatic readParam(input logic [1:0] param, input logic [7:0] exp);
  begin
    partner.sendPkt(FUNC_READ, param, 8'hff, 1'b1);
    @(negedge mclk);
    chkBit("readModeActive", readModeActive, 1'b1);
    chkBit("readbackConnect", readbackConnect, 1'b1);
    for (int i = 7; i >= 0; i--)
    begin
      chkBit("readbackBit", readbackBit, exp[i]);
      if (i == 4)
        partner.sendPkt(FUNC_SENSE, PARAM_GAIN2, 8'h01, 1'b1);
      partner.pulseShift();
      @(negedge mclk);
    end
    chkBit("readModeActive", readModeActive, 1'b0);
    chkBit("readbackBit", readbackBit, 1'b0);
  end
  endtask
  task automatic end_sim();
  begin
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  // watchdog
  initial
  begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    end_sim();
  end
  // ****
  // main sequence
  // ****
  initial
  begin
    rows[0] = {3'h0, 7'h00, 8'h80, 3'b000, 1'b0};
    rows[1] = {3'h0, 7'h00, 8'h00, 3'b001, 1'b0};
    rows[2] = {3'h0, 7'h00, 8'h80, 3'b001, 1'b1};
    rows[3] = {3'h0, 7'h00, 8'h81, 3'b001, 1'b0};
    rows[4] = {3'h0, 7'h01, 8'h00, 3'b001, 1'b1};
    rows[5] = {3'h0, 7'h41, 8'h00, 3'b101, 1'b1};
    rows[6] = {3'h1, 7'h00, 8'h00, 3'b101, 1'b0};
    rows[7] = {3'h7, 7'h7f, 8'hff, 3'b001, 1'b0};
    rows[8] = {3'h1, 7'h01, 8'h80, 3'b101, 1'b0};
    rst_b = 1'b0;
    fuseAboveThreshold = '0;
    wb_adr_i = '0;
    wb_dat_i = '0;
    wb_sel_i = 4'hf;
    wb_we_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    num_errors = 0;
    tests_run = 0;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    @(negedge mclk);
    chkBit("senseLowCurrent", senseLowCurrent, 1'b0);
    wbCycle(CTRL_ADDR, 1'b0, 32'h0);
    chkWord("ctrl", rd, 32'h1);
    // table rows: fuse levels against parity outcome
    for (int i = 0; i < 9; i++)
    begin
      @(posedge mclk);
      fuseAboveThreshold <= rows[i][21:1];
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      chkBit("parityErrorFlag", parityErrorFlag, rows[i][0]);
      chkBit("forceLowRail", forceLowRail, rows[i][0]);
    end
    @(posedge mclk);
    fuseAboveThreshold <= {3'h5, 7'h41, 8'ha5, 3'b001};
    repeat (4) @(posedge mclk);
    partner.sendPkt(FUNC_SENSE, PARAM_GAIN2, 8'hff, 1'b1);
    @(negedge mclk);
    chkBit("senseLowCurrent", senseLowCurrent, 1'b1);
    wbCycle(STATUS_ADDR, 1'b0, 32'h0);
    chkWord("status", rd, 32'h22);
    partner.sendPkt(FUNC_SENSE, PARAM_GAIN2, 8'h00, 1'b0);
    @(negedge mclk);
    chkBit("senseLowCurrent", senseLowCurrent, 1'b1);
    // mid-run reset: the volatile sense choice falls back to normal current
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    @(negedge mclk);
    chkBit("senseLowCurrent", senseLowCurrent, 1'b0);
    readParam(PARAM_OFFSET, 8'ha5);
    partner.sendPkt(FUNC_SENSE, PARAM_GAIN2, 8'hfe, 1'b1);
    readParam(PARAM_GAIN2, 8'h05);
    readParam(PARAM_GAIN1, 8'h41);
    readParam(PARAM_OTHER, 8'h01);
    chkBit("senseLowCurrent", senseLowCurrent, 1'b0);
    wbCycle(CODES_ADDR, 1'b0, 32'h0);
    chkWord("codes", rd, {14'h0, 3'h5, 7'h41, 8'ha5});
    wbCycle(CTRL_ADDR, 1'b1, 32'h0);
    partner.sendPkt(FUNC_READ, PARAM_OFFSET, 8'h00, 1'b1);
    @(negedge mclk);
    chkBit("readModeActive", readModeActive, 1'b0);
    wbCycle(CTRL_ADDR, 1'b1, 32'h1);
    wbCycle(4'h2, 1'b0, 32'h0);
    chkWord("unmapped", rd, 32'h0);
    // lock intact again: simulated codes drive the outputs
    @(posedge mclk);
    fuseAboveThreshold <= {3'h5, 7'h41, 8'ha5, 3'b000};
    repeat (4) @(posedge mclk);
    partner.sendPkt(FUNC_SIMULATE, PARAM_OFFSET, 8'h3c, 1'b1);
    partner.sendPkt(FUNC_SIMULATE, PARAM_OTHER, 8'hff, 1'b1);
    partner.sendPkt(FUNC_PROGRAM, PARAM_OTHER, 8'h04, 1'b1);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chkWord("activeCodes", {14'h0, activeCodes}, 32'h3c);
    wbCycle(STATUS_ADDR, 1'b0, 32'h0);
    chkWord("status", rd, 32'h0);
    // eight words taken since the mid-run reset, refused ones not counted
    wbCycle(PKTCNT_ADDR, 1'b0, 32'h0);
    chkWord("pktcnt", rd, 32'h8);
    end_sim();
  end
endmodule
